// ### inc/ebr_pkg.sv
// Package with register map, field layout and state type of the external bus engine
package ebr_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_RDATA = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  // Configuration, command and status field positions
  localparam int CFG_AB_BIT = 0;
  localparam int CFG_C_LSB = 2;
  localparam int CFG_D_BIT = 4;
  localparam int CFG_E_LSB = 5;
  localparam int CFG_F_LSB = 10;
  localparam int CFG_RDY_EN = 12;
  localparam int CFG_RDY_POL = 13;
  localparam int CFG_RDY_ASYNC = 14;
  localparam int CFG_MUX = 15;
  localparam int CMD_START = 0;
  localparam int CMD_WRITE = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_WAIT_LSB = 8;
  // Reset values
  localparam logic [15:0] CFG_RST = 16'h2000;
  localparam logic [23:0] ADDR_RST = 24'h000000;
  localparam logic [15:0] WDATA_RST = 16'h0000;
  // Reference clock is aclk divided by this many cycles
  localparam int TCS_ACLK = 2;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {
    ST_IDLE, ST_AB, ST_C, ST_D, ST_E, ST_RDY, ST_F
  } ebr_state_t;
endpackage : ebr_pkg

// ### inc/ebr_ready_if.sv
// Interface between cycle engine and ready handshake unit
`timescale 1ns/1ps
interface ebr_ready_if;
  logic pol;
  logic async_mode;
  logic active;
  modport engine (output pol, output async_mode, input active);
  modport unit (input pol, input async_mode, output active);
endinterface : ebr_ready_if

// ### verilog/ebr_ready_unit.sv
// Ready handshake synchroniser and polarity evaluation
`timescale 1ns/1ps
module ebr_ready_unit (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Handshake pin
  input wire logic ready_pin,
  // Engine side
  ebr_ready_if.unit rif
);
  logic s1_reg, s2_reg, s3_reg, filt_reg;
  logic a1_reg, a2_reg, act_reg;
  wire logic sel_level;
  wire logic filt_next;

  // Pin input: change accepted once stages two and three agree
  assign filt_next = (s2_reg == s3_reg) ? s3_reg : filt_reg;
  // Asynchronous mode reads the extra stage, one reference period later
  assign sel_level = rif.async_mode ? a2_reg : filt_reg;
  assign rif.active = act_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      filt_reg <= 1'b0;
      a1_reg <= 1'b0;
      a2_reg <= 1'b0;
      act_reg <= 1'b0;
    end else begin
      s1_reg <= ready_pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      a1_reg <= filt_reg;
      a2_reg <= a1_reg;
      act_reg <= ~(sel_level ^ rif.pol);
    end
  end
endmodule : ebr_ready_unit

// ### verilog/ebr_bus_ctrl.sv
// External parallel bus master with ready handshake and AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module ebr_bus_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External bus strobes and clock
  output logic reference_clock_output,
  output logic cs_n,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  input wire logic ready_in,
  // Address and data lines
  output logic [23:0] dedicated_address_lines,
  output logic [15:0] shared_addr_data_lines_o,
  output logic shared_addr_data_lines_oe,
  input wire logic [15:0] shared_addr_data_lines_i,
  output logic [15:0] dedicated_data_lines_o,
  output logic dedicated_data_lines_oe,
  input wire logic [15:0] dedicated_data_lines_i
);
  ebr_ready_if rif ();

  ebr_ready_unit u_ready (
    .aclk(aclk),
    .aresetn(aresetn),
    .ready_pin(ready_in),
    .rif(rif)
  );

  // Registers
  logic [15:0] cfg_reg;
  logic [23:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic [7:0] wait_reg, wait_next;
  logic start_reg, write_reg;
  ebr_pkg::ebr_state_t state_reg, state_next;
  logic [4:0] cnt_reg, cnt_next;
  logic tick_reg;
  logic [15:0] din1_reg, din2_reg, din3_reg;
  logic aw_have_reg, w_have_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Configuration fields
  wire logic [1:0] len_ab = {1'b0, 1'b1} + {1'b0, cfg_reg[ebr_pkg::CFG_AB_BIT]};
  wire logic [1:0] len_c = cfg_reg[ebr_pkg::CFG_C_LSB +: 2];
  wire logic len_d = cfg_reg[ebr_pkg::CFG_D_BIT];
  wire logic [4:0] len_e = cfg_reg[ebr_pkg::CFG_E_LSB +: 5];
  wire logic [1:0] len_f = cfg_reg[ebr_pkg::CFG_F_LSB +: 2];
  wire logic rdy_en = cfg_reg[ebr_pkg::CFG_RDY_EN];
  wire logic mux_mode = cfg_reg[ebr_pkg::CFG_MUX];

  assign rif.pol = cfg_reg[ebr_pkg::CFG_RDY_POL];
  assign rif.async_mode = cfg_reg[ebr_pkg::CFG_RDY_ASYNC];

  // Phase after the given one, skipping zero-length phases
  function automatic ebr_pkg::ebr_state_t next_phase(input ebr_pkg::ebr_state_t cur,
      input logic [1:0] c, input logic d, input logic [1:0] f);
    ebr_pkg::ebr_state_t n;
    n = ebr_pkg::ST_IDLE;
    case (cur)
      ebr_pkg::ST_AB: n = (c != 2'h0) ? ebr_pkg::ST_C : (d ? ebr_pkg::ST_D : ebr_pkg::ST_E);
      ebr_pkg::ST_C: n = d ? ebr_pkg::ST_D : ebr_pkg::ST_E;
      ebr_pkg::ST_D: n = ebr_pkg::ST_E;
      ebr_pkg::ST_E, ebr_pkg::ST_RDY: n = (f != 2'h0) ? ebr_pkg::ST_F : ebr_pkg::ST_IDLE;
      default: n = ebr_pkg::ST_IDLE;
    endcase
    return n;
  endfunction : next_phase

  // Remaining count minus one for a phase
  function automatic logic [4:0] phase_cnt(input ebr_pkg::ebr_state_t st, input logic [1:0] ab,
      input logic [1:0] c, input logic [4:0] e, input logic [1:0] f);
    logic [4:0] n;
    n = 5'h00;
    case (st)
      ebr_pkg::ST_AB: n = {3'h0, ab} - 5'h01;
      ebr_pkg::ST_C: n = {3'h0, c} - 5'h01;
      ebr_pkg::ST_E: n = e;
      ebr_pkg::ST_F: n = {3'h0, f} - 5'h01;
      default: n = 5'h00;
    endcase
    return n;
  endfunction : phase_cnt

  // Cycle engine, advancing once per reference clock period
  wire logic in_access = (state_reg == ebr_pkg::ST_E) || (state_reg == ebr_pkg::ST_RDY);
  wire logic sample_pt = tick_reg && in_access && (cnt_reg == 5'h00);
  wire logic rdy_ok = !rdy_en || rif.active;
  wire logic finish = sample_pt && rdy_ok;
  wire ebr_pkg::ebr_state_t after_acc = next_phase(state_reg, len_c, len_d, len_f);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    wait_next = wait_reg;
    if (tick_reg) begin
      case (state_reg)
        ebr_pkg::ST_IDLE: begin
          if (start_reg) begin
            state_next = ebr_pkg::ST_AB;
            cnt_next = phase_cnt(ebr_pkg::ST_AB, len_ab, len_c, len_e, len_f);
            wait_next = 8'h00;
          end
        end
        ebr_pkg::ST_E, ebr_pkg::ST_RDY: begin
          if (cnt_reg != 5'h00) begin
            cnt_next = cnt_reg - 5'h01;
          end else if (rdy_ok) begin
            state_next = after_acc;
            cnt_next = phase_cnt(after_acc, len_ab, len_c, len_e, len_f);
          end else begin
            state_next = ebr_pkg::ST_RDY;
            wait_next = wait_reg + 8'h01;
          end
        end
        ebr_pkg::ST_AB, ebr_pkg::ST_C, ebr_pkg::ST_D, ebr_pkg::ST_F: begin
          if (cnt_reg != 5'h00) begin
            cnt_next = cnt_reg - 5'h01;
          end else begin
            state_next = next_phase(state_reg, len_c, len_d, len_f);
            cnt_next = phase_cnt(state_next, len_ab, len_c, len_e, len_f);
          end
        end
        default: begin
          state_next = ebr_pkg::ST_IDLE;
          cnt_next = 5'h00;
        end
      endcase
    end
  end

  // Pin levels from the coming state
  wire logic nx_busy = (state_next != ebr_pkg::ST_IDLE);
  wire logic nx_ab = (state_next == ebr_pkg::ST_AB);
  wire logic nx_cmd = (state_next == ebr_pkg::ST_D) || (state_next == ebr_pkg::ST_E) ||
                      (state_next == ebr_pkg::ST_RDY);
  wire logic nx_wdata = nx_busy && !nx_ab && (state_next != ebr_pkg::ST_C) && write_reg;
  wire logic nx_ad_addr = mux_mode && nx_busy && (nx_ab || state_next == ebr_pkg::ST_C);
  wire logic [15:0] din_filt = (din2_reg == din3_reg) ? din3_reg : rdata_reg;
  wire logic [15:0] din_bus = mux_mode ? shared_addr_data_lines_i : dedicated_data_lines_i;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ebr_pkg::ST_IDLE;
      cnt_reg <= 5'h00;
      wait_reg <= 8'h00;
      tick_reg <= 1'b0;
      reference_clock_output <= 1'b0;
      cs_n <= 1'b1;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      dedicated_address_lines <= ebr_pkg::ADDR_RST;
      shared_addr_data_lines_o <= 16'h0000;
      shared_addr_data_lines_oe <= 1'b0;
      dedicated_data_lines_o <= 16'h0000;
      dedicated_data_lines_oe <= 1'b0;
      rdata_reg <= 16'h0000;
      din1_reg <= 16'h0000;
      din2_reg <= 16'h0000;
      din3_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      wait_reg <= wait_next;
      tick_reg <= !tick_reg;
      reference_clock_output <= !tick_reg;
      cs_n <= !nx_busy;
      ale <= nx_ab;
      rd_n <= !(nx_cmd && !write_reg);
      wr_n <= !(nx_cmd && write_reg);
      dedicated_address_lines <= nx_busy ? addr_reg : dedicated_address_lines;
      shared_addr_data_lines_o <= nx_ad_addr ? addr_reg[15:0] : wdata_reg;
      shared_addr_data_lines_oe <= nx_ad_addr || (mux_mode && nx_wdata);
      dedicated_data_lines_o <= wdata_reg;
      dedicated_data_lines_oe <= !mux_mode && nx_wdata;
      din1_reg <= din_bus;
      din2_reg <= din1_reg;
      din3_reg <= din2_reg;
      if (finish && !write_reg) begin
        rdata_reg <= din_filt;
      end
    end
  end

  // AXI4-Lite slave: decode
  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire logic wr_cfg = wr_go && (aw_addr_reg == ebr_pkg::OFF_CFG);
  wire logic wr_addr = wr_go && (aw_addr_reg == ebr_pkg::OFF_ADDR);
  wire logic wr_wdat = wr_go && (aw_addr_reg == ebr_pkg::OFF_WDATA);
  wire logic wr_cmd = wr_go && (aw_addr_reg == ebr_pkg::OFF_CMD);
  wire logic wr_hit = wr_cfg || wr_addr || wr_wdat || wr_cmd ||
                      (aw_addr_reg == ebr_pkg::OFF_RDATA) || (aw_addr_reg == ebr_pkg::OFF_STAT);
  wire logic busy = start_reg || (state_reg != ebr_pkg::ST_IDLE);
  wire logic launch = wr_cmd && w_strb_reg[0] && w_data_reg[ebr_pkg::CMD_START] && !busy;
  wire logic rd_take = s_axi_arvalid && s_axi_arready;
  wire logic [31:0] stat_word = {16'h0000, wait_reg, 7'h00, busy};
  wire logic rd_hit = (s_axi_araddr == ebr_pkg::OFF_CFG) || (s_axi_araddr == ebr_pkg::OFF_ADDR) ||
                      (s_axi_araddr == ebr_pkg::OFF_WDATA) || (s_axi_araddr == ebr_pkg::OFF_CMD) ||
                      (s_axi_araddr == ebr_pkg::OFF_RDATA) || (s_axi_araddr == ebr_pkg::OFF_STAT);
  wire logic [31:0] rd_word =
      (s_axi_araddr == ebr_pkg::OFF_CFG) ? {16'h0000, cfg_reg} :
      (s_axi_araddr == ebr_pkg::OFF_ADDR) ? {8'h00, addr_reg} :
      (s_axi_araddr == ebr_pkg::OFF_WDATA) ? {16'h0000, wdata_reg} :
      (s_axi_araddr == ebr_pkg::OFF_CMD) ? {30'h0, write_reg, busy} :
      (s_axi_araddr == ebr_pkg::OFF_RDATA) ? {16'h0000, rdata_reg} :
      (s_axi_araddr == ebr_pkg::OFF_STAT) ? stat_word : 32'h00000000;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
      input logic [3:0] be);
    return {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ebr_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= ebr_pkg::RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      cfg_reg <= ebr_pkg::CFG_RST;
      addr_reg <= ebr_pkg::ADDR_RST;
      wdata_reg <= ebr_pkg::WDATA_RST;
      start_reg <= 1'b0;
      write_reg <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_reg && !aw_take;
      s_axi_wready <= !w_have_reg && !w_take;
      if (aw_take) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ebr_pkg::RESP_OKAY : ebr_pkg::RESP_DECERR;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_cfg && !busy) begin
        cfg_reg <= merge16(cfg_reg, w_data_reg, w_strb_reg);
      end
      if (wr_addr && !busy) begin
        addr_reg <= {w_strb_reg[2] ? w_data_reg[23:16] : addr_reg[23:16],
                     merge16(addr_reg[15:0], w_data_reg, w_strb_reg)};
      end
      if (wr_wdat && !busy) begin
        wdata_reg <= merge16(wdata_reg, w_data_reg, w_strb_reg);
      end
      if (launch) begin
        start_reg <= 1'b1;
        write_reg <= w_data_reg[ebr_pkg::CMD_WRITE];
      end else if (tick_reg && state_reg == ebr_pkg::ST_IDLE) begin
        start_reg <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? ebr_pkg::RESP_OKAY : ebr_pkg::RESP_DECERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : ebr_bus_ctrl

// ### tb/ebr_bus_checker.sv
// Concurrent checks on the external bus pins of the bus engine
`timescale 1ns/1ps
module ebr_bus_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // External bus
  input wire logic reference_clock_output,
  input wire logic cs_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [23:0] dedicated_address_lines,
  input wire logic [15:0] shared_addr_data_lines_o,
  input wire logic shared_addr_data_lines_oe,
  input wire logic dedicated_data_lines_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_refclk_toggles: assert property ($past(aresetn) |->
    reference_clock_output != $past(reference_clock_output)) else $error("refclk stuck");
  a_one_strobe: assert property (rd_n || wr_n) else $error("both strobes low");
  a_strobe_in_cycle: assert property ((!rd_n || !wr_n || ale) |-> !cs_n)
    else $error("strobe outside cycle");
  a_min_cycle_len: assert property ($fell(cs_n) |-> ale [*2] ##1 !cs_n [*2])
    else $error("cycle too short");
  a_idle_gap: assert property ($rose(cs_n) |-> cs_n [*2]) else $error("idle gap short");
  a_access_base: assert property ($fell(rd_n) |-> !rd_n [*2]) else $error("access short");
  a_mux_addr_first: assert property ((ale && shared_addr_data_lines_oe) |->
    shared_addr_data_lines_o == dedicated_address_lines[15:0]) else $error("mux address");
  a_read_released: assert property (!rd_n |->
    !shared_addr_data_lines_oe && !dedicated_data_lines_oe) else $error("driving in read");
  a_write_one_bus: assert property (!wr_n |->
    shared_addr_data_lines_oe != dedicated_data_lines_oe) else $error("write lines");
  a_addr_steady: assert property ((!cs_n && !$past(cs_n)) |->
    $stable(dedicated_address_lines)) else $error("address moved");
endmodule : ebr_bus_checker

bind ebr_bus_ctrl ebr_bus_checker ebr_bus_checker_i (.aclk, .aresetn, .reference_clock_output,
  .cs_n, .ale, .rd_n, .wr_n, .dedicated_address_lines, .shared_addr_data_lines_o,
  .shared_addr_data_lines_oe, .dedicated_data_lines_oe);

// ### tb/ebr_ext_model.sv
// Behavioural external memory with a programmable ready handshake
`timescale 1ns/1ps
module ebr_ext_model (
  // Clocks
  input wire logic aclk,
  input wire logic reference_clock_output,
  // Bus from device
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [23:0] dedicated_address_lines,
  input wire logic [15:0] wr_data,
  // Handshake setup
  input wire logic pol,
  input wire logic async_mode,
  input wire logic [7:0] rdy_delay,
  // Answers
  output logic ready_in,
  output logic [15:0] rd_data
);
  logic [15:0] mem [16];
  logic [7:0] cnt;
  wire strobe = !(rd_n && wr_n);
  wire act = (rdy_delay == 8'h00) || (rdy_delay != 8'hFF && strobe && cnt >= rdy_delay);
  initial begin
    ready_in = 1'b0;
    rd_data = 16'h0000;
    cnt = 8'h00;
  end
  always @(posedge reference_clock_output) cnt <= strobe ? cnt + 8'h01 : 8'h00;
  // Drops with the rising strobe; sync follows refclk, async lands off phase
  always @(act, pol) ready_in <= #(async_mode ? 17 : 1) (act ~^ pol);
  // Drives while selected for reads, else a pattern changing every cycle
  always @(posedge aclk) begin
    rd_data <= (!cs_n && wr_n) ? mem[dedicated_address_lines[3:0]] : ~rd_data;
    if (!wr_n) begin
      mem[dedicated_address_lines[3:0]] <= wr_data;
    end
  end
endmodule : ebr_ext_model

// ### tb/ebr_bus_ctrl_tb_top.sv
// Self-checking bench for the external bus engine
`timescale 1ns/1ps
module ebr_bus_ctrl_tb_top;
  typedef struct {logic mux; int ab, c, d, e, f; logic [23:0] a; logic [15:0] dat;} ebr_row_t;
  ebr_row_t rows [4] = '{'{1'b0, 1, 0, 0, 2, 0, 24'h000003, 16'hA5C3},
    '{1'b1, 2, 3, 1, 2, 3, 24'h123456, 16'h5A3C}, '{1'b0, 2, 1, 1, 32, 1, 24'hFFFFF9, 16'hFFFF},
    '{1'b1, 1, 0, 1, 3, 0, 24'h80000A, 16'h0001}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ready_in;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cs_q, pol, asy;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic reference_clock_output, cs_n, ale, rd_n, wr_n, ad_oe, d_oe;
  logic [23:0] dedicated_address_lines;
  logic [15:0] ad_o, d_o, rd_data, cfg;
  logic [7:0] dly, wst, w1, w2;
  int fail_count, check_count, cyc, cs_len, st_len;
  always #12.5 aclk = ~aclk;
  ebr_bus_ctrl ebr_bus_ctrl_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .reference_clock_output, .cs_n, .ale, .rd_n, .wr_n, .ready_in,
    .dedicated_address_lines, .shared_addr_data_lines_o(ad_o), .shared_addr_data_lines_oe(ad_oe),
    .shared_addr_data_lines_i(ad_oe ? ad_o : rd_data), .dedicated_data_lines_o(d_o),
    .dedicated_data_lines_oe(d_oe), .dedicated_data_lines_i(d_oe ? d_o : rd_data));
  ebr_ext_model ebr_ext_model_i (.aclk, .reference_clock_output, .cs_n, .rd_n, .wr_n,
    .dedicated_address_lines, .wr_data(d_oe ? d_o : ad_o), .pol, .async_mode(asy),
    .rdy_delay(dly), .ready_in, .rd_data);
  // Cycle and strobe lengths of the last bus cycle
  always @(posedge aclk) begin
    cs_q <= cs_n;
    if (!cs_n) cs_len <= cs_q ? 1 : cs_len + 1;
    if (!cs_n && cs_q) st_len <= 0;
    else if (!(rd_n && wr_n)) st_len <= st_len + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("BAD %0t timeout", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    {aw, w} = 2'h3;
    forever begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd
  function automatic logic [15:0] mk(input int ab, c, d, e, f, input logic en, p, as, mux);
    mk = {mux, as, p, en, 2'(f), 5'(e - 1), 1'(d), 2'(c), 1'b0, 1'(ab - 1)};
  endfunction : mk
  task automatic run(input logic [23:0] a, input logic [15:0] d, input logic w);
    wr(ebr_pkg::OFF_CFG, {16'h0000, cfg});
    wr(ebr_pkg::OFF_ADDR, {8'h00, a});
    wr(ebr_pkg::OFF_WDATA, {16'h0000, d});
    wr(ebr_pkg::OFF_CMD, {30'h0, w, 1'b1});
    repeat (3) @(posedge aclk);
    v = 32'h1;
    while (v[0]) rd(ebr_pkg::OFF_STAT);
    wst = v[15:8];
  endtask : run
  task automatic rdy(input logic p, input logic as, input int e, input logic [7:0] n);
    pol <= p;
    asy <= as;
    dly <= n;
    cfg = mk(1, 0, 0, e, 0, n != 8'hFF, p, as, 1'b0);
    run(24'h000005, 16'h1234, 1'b1);
    chk(cs_len, 2 * (1 + e + wst));
  endtask : rdy
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    {pol, asy, dly, cs_q} = {2'b10, 8'hFF, 1'b1};
    {fail_count, check_count, cyc} = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ebr_pkg::OFF_CFG);
    chk(v, {16'h0, ebr_pkg::CFG_RST});
    rd(8'h20);
    chk(r, ebr_pkg::RESP_DECERR);
    wr(8'h20, 32'h0);
    chk(r, ebr_pkg::RESP_DECERR);
    foreach (rows[i]) begin
      cfg = mk(rows[i].ab, rows[i].c, rows[i].d, rows[i].e, rows[i].f, 0, 1, 0, rows[i].mux);
      run(rows[i].a, rows[i].dat, 1'b1);
      chk(cs_len, 2 * (rows[i].ab + rows[i].c + rows[i].d + rows[i].e + rows[i].f));
      chk(st_len, 2 * (rows[i].d + rows[i].e));
      run(rows[i].a, 16'h0000, 1'b0);
      rd(ebr_pkg::OFF_RDATA);
      chk(v, {16'h0, rows[i].dat});
      chk(dedicated_address_lines, {8'h00, rows[i].a});
    end
    rdy(1'b1, 1'b0, 1, 8'h02);
    w1 = wst;
    chk(w1 > 0, 1);
    rdy(1'b1, 1'b0, 1, 8'h03);
    w2 = wst;
    chk(w2, w1 + 1);
    rdy(1'b0, 1'b0, 1, 8'h03);
    chk(wst, w2);
    rdy(1'b1, 1'b1, 1, 8'h03);
    chk(wst > w2, 1);
    rdy(1'b1, 1'b0, 1, 8'hFF);
    chk(wst, 0);
    rdy(1'b1, 1'b0, 4, 8'h00);
    chk(wst, 0);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ebr_pkg::OFF_CFG);
    chk(v, {16'h0, ebr_pkg::CFG_RST});
    close_out();
  end
endmodule : ebr_bus_ctrl_tb_top
